// ===== src/cache_dis_pkg.sv
// constants, field positions and state codes for the cache disable sequencer
// assumes one 250 MHz clock and an asynchronous active-high reset
package cache_dis_pkg;

	// ----------------------------------------------------------------
	// interrupt status layout
	// ----------------------------------------------------------------
	localparam int IRQ_W = 4;
	localparam int IRQ_DISABLE_DONE = 0;
	localparam int IRQ_MAINT_DONE = 1;
	localparam int IRQ_MAINT_IGNORED = 2;
	localparam int IRQ_ENABLE_DONE = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// ----------------------------------------------------------------
	// whole-cache maintenance trigger field
	// ----------------------------------------------------------------
	localparam int TRIG_CLEAN_BIT = 0;
	localparam int TRIG_INVAL_BIT = 1;
	localparam logic [1:0] MAINT_NONE = 2'h0;
	localparam logic [1:0] MAINT_CLEAN = 2'h1;
	localparam logic [1:0] MAINT_INVAL = 2'h2;
	localparam logic [1:0] MAINT_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic CACHE_ON_RESET = 1'b0;
	localparam logic GRANT_RESET = 1'b0;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_MANUAL = 4'h2,
		ST_AUTO = 4'h4,
		ST_APPLY = 4'h8
	} seq_state_t;

endpackage

// ===== src/cache_disable_sequencer.sv
// cache on/off sequencer with auto clean, bus stall and secure rights
// assumes command strobes are one-cycle pulses synchronous to ref_clk
// and that an outside maintenance engine answers maint_start with
// one maint_done pulse
module cache_disable_sequencer
	import cache_dis_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic dis_maint_bypass,
	input wire logic cfg_write,
	input wire logic cfg_secure,
	input wire logic cfg_enable_bit,
	input wire logic cfg_grant_bit,
	input wire logic maint_req,
	input wire logic maint_secure,
	input wire logic [1:0] maint_type,
	input wire logic maint_done,
	input wire logic irq_clear_write,
	input wire logic [cache_dis_pkg::IRQ_W-1:0] irq_clear_data,
	input wire logic irq_enable_write,
	input wire logic [cache_dis_pkg::IRQ_W-1:0] irq_enable_data,
	input wire logic state_read_req,
	input wire logic state_read_secure,
	output logic cache_enabled,
	output logic ongoing_en_dis,
	output logic ongoing_maint,
	output logic ahb_stall,
	output logic maint_start,
	output logic [1:0] maint_kind,
	output logic ns_state_read_granted,
	output logic state_read_valid,
	output logic state_read_data,
	output logic state_read_refused,
	output logic [cache_dis_pkg::IRQ_W-1:0] secure_irq_status,
	output logic [cache_dis_pkg::IRQ_W-1:0] secure_irq_enable,
	output logic secure_irq
);

	seq_state_t state_reg;
	seq_state_t state_next;
	logic pend_reg;
	logic pend_next;
	logic target_reg;
	logic target_next;
	logic sec_wr;
	logic dis_req;
	logic en_req;
	logic maint_ok;
	logic maint_bad;
	logic [IRQ_W-1:0] irq_set;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------

	// only secure writes reach the on/off control
	always_comb begin
		sec_wr = cfg_write && cfg_secure;
		// zero in the enable bit is the disable command
		dis_req = sec_wr && !cfg_enable_bit
			&& cache_enabled && !ongoing_en_dis;
		en_req = sec_wr && cfg_enable_bit && !cache_enabled
			&& (state_reg == ST_IDLE);
		// disabled cache takes invalidate-all only
		maint_ok = maint_req && maint_secure && (maint_type != MAINT_NONE)
			&& (state_reg == ST_IDLE)
			&& (cache_enabled || maint_type == MAINT_INVAL);
		maint_bad = maint_req && (maint_type != MAINT_NONE) && !maint_ok;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------

	// next state, pending disable and transition target
	always_comb begin
		state_next = state_reg;
		pend_next = pend_reg;
		target_next = target_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (maint_ok) begin
					state_next = ST_MANUAL;
					pend_next = dis_req;
					target_next = 1'b0;
				end else if (dis_req) begin
					target_next = 1'b0;
					// bypass applies the disable without cleaning
					state_next = dis_maint_bypass ? ST_APPLY
						: ST_AUTO;
				end else if (en_req) begin
					target_next = 1'b1;
					state_next = ST_APPLY;
				end
			end
			ST_MANUAL: begin
				if (dis_req) begin
					pend_next = 1'b1;
				end
				if (maint_done) begin
					pend_next = 1'b0;
					if (pend_reg || dis_req) begin
						state_next = dis_maint_bypass ? ST_APPLY : ST_AUTO;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_AUTO: begin
				// disable applies only after the clean ends
				if (maint_done) begin
					state_next = ST_APPLY;
				end
			end
			ST_APPLY: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// pending disable and direction of transition
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_reg <= 1'b0;
			target_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			target_reg <= target_next;
		end
	end

	// enabled status changes only as the transition completes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cache_enabled <= CACHE_ON_RESET;
		end else if (state_reg == ST_APPLY) begin
			cache_enabled <= target_reg;
		end
	end

	// status flags and bus stall follow the next state
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ongoing_en_dis <= 1'b0;
			ongoing_maint <= 1'b0;
			ahb_stall <= 1'b0;
		end else begin
			ongoing_en_dis <= (state_next == ST_AUTO)
				|| (state_next == ST_APPLY) || pend_next;
			ongoing_maint <= (state_next == ST_MANUAL);
			ahb_stall <= (state_next == ST_AUTO);
		end
	end

	// start pulse and kind for the maintenance engine
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			maint_start <= 1'b0;
			maint_kind <= MAINT_NONE;
		end else begin
			maint_start <= 1'b0;
			if (state_reg != ST_MANUAL && state_next == ST_MANUAL) begin
				maint_start <= 1'b1;
				maint_kind <= maint_type;
			end else if (state_reg != ST_AUTO && state_next == ST_AUTO) begin
				maint_start <= 1'b1;
				maint_kind <= MAINT_CLEAN;
			end
		end
	end

	// ----------------------------------------------------------------
	// non-secure rights
	// ----------------------------------------------------------------

	// grant bit, shown in the rights status
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ns_state_read_granted <= GRANT_RESET;
		end else if (sec_wr) begin
			ns_state_read_granted <= cfg_grant_bit;
		end
	end

	// state read answer, refused for ungranted non-secure reads
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_read_valid <= 1'b0;
			state_read_data <= 1'b0;
			state_read_refused <= 1'b0;
		end else begin
			state_read_valid <= 1'b0;
			state_read_refused <= 1'b0;
			state_read_data <= 1'b0;
			if (state_read_req) begin
				if (state_read_secure || ns_state_read_granted) begin
					state_read_valid <= 1'b1;
					state_read_data <= cache_enabled;
				end else begin
					state_read_refused <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags
	// ----------------------------------------------------------------

	// completion and ignored-request events
	always_comb begin
		irq_set = IRQ_RESET;
		irq_set[IRQ_DISABLE_DONE] = (state_reg == ST_APPLY)
			&& !target_reg;
		irq_set[IRQ_ENABLE_DONE] = (state_reg == ST_APPLY) && target_reg;
		irq_set[IRQ_MAINT_DONE] = (state_reg == ST_MANUAL)
			&& maint_done;
		irq_set[IRQ_MAINT_IGNORED] = maint_bad;
	end

	secure_irq_regs irq_regs (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.set_vec(irq_set),
		.clear_write(irq_clear_write),
		.clear_data(irq_clear_data),
		.enable_write(irq_enable_write),
		.enable_data(irq_enable_data),
		.secure_irq_status(secure_irq_status),
		.secure_irq_enable(secure_irq_enable),
		.secure_irq(secure_irq)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	ns_write_inert_a: assert property (
		(cfg_write && !cfg_secure && state_reg == ST_IDLE && !maint_req)
		|=> state_reg == ST_IDLE && $stable(cache_enabled))
		else $error("non-secure write changed on/off state");

	auto_clean_a: assert property (
		(state_reg == ST_IDLE && dis_req && !maint_ok && !dis_maint_bypass)
		|=> maint_start && maint_kind == MAINT_CLEAN && ahb_stall
		##1 cache_enabled)
		else $error("disable did not start auto clean first");

	stall_hold_a: assert property (
		state_reg == ST_AUTO |-> ahb_stall)
		else $error("bus not stalled during auto clean");

	disable_write_a: assert property (
		(state_reg == ST_IDLE && sec_wr && !cfg_enable_bit && cache_enabled
			&& !maint_req && dis_maint_bypass)
		|=> ongoing_en_dis ##1 !cache_enabled)
		else $error("zero enable write did not disable");

	fall_flag_a: assert property (
		$fell(cache_enabled) |-> secure_irq_status[IRQ_DISABLE_DONE])
		else $error("disable done flag missing at completion");

	bypass_clean_a: assert property (
		(state_reg == ST_IDLE && dis_req && !maint_ok && dis_maint_bypass)
		|=> !maint_start && !ahb_stall)
		else $error("bypassed disable started maintenance");

	order_keep_a: assert property (
		(state_reg == ST_MANUAL && pend_reg && maint_done && dis_maint_bypass)
		|=> state_reg == ST_APPLY ##1 !cache_enabled)
		else $error("queued disable not applied after clean");

	manual_end_a: assert property (
		(state_reg == ST_MANUAL && maint_done && !pend_reg && !dis_req)
		|=> !ongoing_maint && secure_irq_status[IRQ_MAINT_DONE])
		else $error("manual clean end not reported");

	ns_refuse_a: assert property (
		(state_read_req && !state_read_secure && !ns_state_read_granted)
		|=> state_read_refused && !state_read_valid)
		else $error("ungranted non-secure read answered");

	enabled_change_a: assert property (
		$changed(cache_enabled) |-> $past(ongoing_en_dis))
		else $error("enabled bit changed outside a transition");

	off_maint_a: assert property (
		(maint_req && !cache_enabled && maint_type == MAINT_CLEAN)
		|=> !maint_start && secure_irq_status[IRQ_MAINT_IGNORED])
		else $error("disabled cache accepted clean maintenance");

	already_off_a: assert property (
		(sec_wr && !cfg_enable_bit && !cache_enabled
			&& state_reg == ST_IDLE && !maint_req)
		|=> !maint_start && state_reg == ST_IDLE)
		else $error("disable of disabled cache did something");

endmodule

// ===== src/secure_irq_regs.sv
// secure interrupt status, enable and clear logic
// assumes set pulses from the sequencer and write strobes from software
module secure_irq_regs
	import cache_dis_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [cache_dis_pkg::IRQ_W-1:0] set_vec,
	input wire logic clear_write,
	input wire logic [cache_dis_pkg::IRQ_W-1:0] clear_data,
	input wire logic enable_write,
	input wire logic [cache_dis_pkg::IRQ_W-1:0] enable_data,
	output logic [cache_dis_pkg::IRQ_W-1:0] secure_irq_status,
	output logic [cache_dis_pkg::IRQ_W-1:0] secure_irq_enable,
	output logic secure_irq
);

	logic [IRQ_W-1:0] status_next;
	logic [IRQ_W-1:0] enable_next;

	// ----------------------------------------------------------------
	// next values: a set in the clear cycle survives
	// ----------------------------------------------------------------
	always_comb begin
		status_next = secure_irq_status;
		if (clear_write) begin
			status_next = status_next & ~clear_data;
		end
		status_next = status_next | set_vec;
		enable_next = enable_write ? enable_data : secure_irq_enable;
	end

	// status flags
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			secure_irq_status <= IRQ_RESET;
		end else begin
			secure_irq_status <= status_next;
		end
	end

	// enable mask
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			secure_irq_enable <= IRQ_RESET;
		end else begin
			secure_irq_enable <= enable_next;
		end
	end

	// registered interrupt line, aligned with the flags
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			secure_irq <= 1'b0;
		end else begin
			secure_irq <= |(status_next & enable_next);
		end
	end

	clear_one_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(clear_write && clear_data[IRQ_MAINT_DONE]
			&& !set_vec[IRQ_MAINT_DONE])
		|=> !secure_irq_status[IRQ_MAINT_DONE])
		else $error("write-one did not clear pending flag");

	clear_zero_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(clear_write && !clear_data[IRQ_DISABLE_DONE]
			&& secure_irq_status[IRQ_DISABLE_DONE])
		|=> secure_irq_status[IRQ_DISABLE_DONE])
		else $error("zero bit in clear write changed a flag");

	irq_gate_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		secure_irq == (|(secure_irq_status & secure_irq_enable)))
		else $error("interrupt line disagrees with flags and mask");

endmodule

// ===== verification/cache_disable_sequencer_bench.sv
// self-checking bench for the cache disable sequencer
// assumes the maintenance engine model answers every maint_start
module cache_disable_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import cache_dis_pkg::*;
	logic ref_clk, sys_rst, dis_maint_bypass, cfg_write, cfg_secure;
	logic cfg_enable_bit, cfg_grant_bit, maint_req, maint_secure;
	logic [1:0] maint_type, maint_kind;
	logic maint_done, irq_clear_write, irq_enable_write;
	logic [IRQ_W-1:0] irq_clear_data, irq_enable_data;
	logic [IRQ_W-1:0] secure_irq_status, secure_irq_enable;
	logic state_read_req, state_read_secure, cache_enabled, ongoing_en_dis;
	logic ongoing_maint, ahb_stall, maint_start, ns_state_read_granted;
	logic state_read_valid, state_read_data, state_read_refused, secure_irq;
	logic [7:0] lat;
	logic [31:0] seed;
	logic [1:0] tt [4] = '{2'h1, 2'h3, 2'h2, 2'h2};
	int n_errors, n_checks, n_starts, st0, i;

	cache_disable_sequencer u_cache_disable_sequencer (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.dis_maint_bypass(dis_maint_bypass), .cfg_write(cfg_write),
		.cfg_secure(cfg_secure), .cfg_enable_bit(cfg_enable_bit),
		.cfg_grant_bit(cfg_grant_bit), .maint_req(maint_req),
		.maint_secure(maint_secure), .maint_type(maint_type),
		.maint_done(maint_done), .irq_clear_write(irq_clear_write),
		.irq_clear_data(irq_clear_data),
		.irq_enable_write(irq_enable_write),
		.irq_enable_data(irq_enable_data),
		.state_read_req(state_read_req),
		.state_read_secure(state_read_secure),
		.cache_enabled(cache_enabled), .ongoing_en_dis(ongoing_en_dis),
		.ongoing_maint(ongoing_maint), .ahb_stall(ahb_stall),
		.maint_start(maint_start), .maint_kind(maint_kind),
		.ns_state_read_granted(ns_state_read_granted),
		.state_read_valid(state_read_valid),
		.state_read_data(state_read_data),
		.state_read_refused(state_read_refused),
		.secure_irq_status(secure_irq_status),
		.secure_irq_enable(secure_irq_enable), .secure_irq(secure_irq));

	maint_engine_model u_maint_engine_model (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .maint_start(maint_start), .lat(lat),
		.maint_done(maint_done));

	// ----------------------------------------------------------------
	// clock, start counter and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// count maintenance starts seen by the engine
	always @(posedge ref_clk) begin
		if (maint_start === 1'b1) n_starts++;
	end

	// cut a hang short well past the expected run length
	initial begin
		repeat (4000) @(posedge ref_clk);
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		finish_test();
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string w);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t %s got %b exp %b", $time, w, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp,
		input string w);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	// each request task returns in the cycle after the taking edge
	task automatic cfg_wr(input logic s, input logic e, input logic g);
		cfg_secure = s;
		cfg_enable_bit = e;
		cfg_grant_bit = g;
		cfg_write = 1'b1;
		tick();
		cfg_write = 1'b0;
	endtask

	task automatic mreq(input logic s, input logic [1:0] t);
		maint_secure = s;
		maint_type = t;
		maint_req = 1'b1;
		tick();
		maint_req = 1'b0;
	endtask

	task automatic clr(input logic [3:0] d);
		irq_clear_data = d;
		irq_clear_write = 1'b1;
		tick();
		irq_clear_write = 1'b0;
	endtask

	task automatic ien(input logic [3:0] d);
		irq_enable_data = d;
		irq_enable_write = 1'b1;
		tick();
		irq_enable_write = 1'b0;
	endtask

	task automatic rd(input logic s);
		state_read_secure = s;
		state_read_req = 1'b1;
		tick();
		state_read_req = 1'b0;
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{cfg_write, cfg_secure, cfg_enable_bit, cfg_grant_bit} = 4'h0;
		{maint_req, maint_secure, maint_type} = 4'h0;
		{irq_clear_write, irq_enable_write} = 2'h0;
		{irq_clear_data, irq_enable_data} = 8'h00;
		{state_read_req, state_read_secure} = 2'h0;
		dis_maint_bypass = 1'b1;
		lat = 8'h00;
		seed = 32'h0001106b;
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		chk_bit(cache_enabled, CACHE_ON_RESET, "reset on");
		chk_vec(secure_irq_status, IRQ_RESET, "reset status");
		chk_bit(ns_state_read_granted, GRANT_RESET, "reset grant");
		done("reset");
		// non-secure enable ignored, then secure enable
		cfg_wr(1'b0, 1'b1, 1'b0);
		tick();
		chk_bit(cache_enabled, 1'b0, "ns enable");
		cfg_wr(1'b1, 1'b1, 1'b0);
		tick();
		chk_vec(secure_irq_status, 4'h8, "enable flag");
		clr(4'h7);
		chk_vec(secure_irq_status, 4'h8, "zero bits");
		// let an edge pass so the clear strobe drops between writes
		tick();
		clr(4'h8);
		chk_vec(secure_irq_status, 4'h0, "one bit");
		done("enable_clear");
		// clean and invalidate while on
		mreq(1'b1, MAINT_BOTH);
		chk_bit(maint_start, 1'b1, "both start");
		chk_vec({2'h0, maint_kind}, 4'h3, "both kind");
		for (i = 0; i < 40 && ongoing_maint !== 1'b0; i++) tick();
		chk_vec(secure_irq_status, 4'h2, "both done");
		clr(4'hf);
		done("maint_on");
		// bypass high disable with interrupt
		chk_vec(secure_irq_status, 4'h0, "no pending");
		ien(4'h1);
		cfg_wr(1'b1, 1'b0, 1'b0);
		chk_bit(ongoing_en_dis, 1'b1, "ongoing");
		chk_bit(cache_enabled, 1'b1, "not yet off");
		chk_bit(maint_start, 1'b0, "no clean");
		chk_bit(ahb_stall, 1'b0, "no stall");
		tick();
		chk_bit(cache_enabled, 1'b0, "off");
		chk_vec(secure_irq_status, 4'h1, "dis flag");
		chk_bit(secure_irq, 1'b1, "irq up");
		clr(4'h1);
		chk_bit(secure_irq, 1'b0, "irq down");
		done("bypass_disable");
		// disable while off, then maintenance table while off
		cfg_wr(1'b1, 1'b0, 1'b0);
		chk_bit(ongoing_en_dis, 1'b0, "idle");
		chk_bit(maint_start, 1'b0, "idle start");
		for (int k = 0; k < 4; k++) begin
			mreq(k != 2, tt[k]);
			chk_bit(maint_start, k == 3, "off maint");
			tick();
		end
		chk_vec({2'h0, maint_kind}, 4'h2, "inval kind");
		for (i = 0; i < 40 && ongoing_maint !== 1'b0; i++) tick();
		chk_vec(secure_irq_status, 4'h6, "ignored");
		clr(4'hf);
		done("off_maint");
		// grant of non-secure state reads
		rd(1'b0);
		chk_bit(state_read_refused, 1'b1, "refused");
		chk_bit(state_read_valid, 1'b0, "no data");
		cfg_wr(1'b1, 1'b0, 1'b1);
		chk_bit(ns_state_read_granted, 1'b1, "granted");
		rd(1'b0);
		chk_bit(state_read_valid, 1'b1, "read ok");
		chk_bit(state_read_data, 1'b0, "read off");
		cfg_wr(1'b0, 1'b0, 1'b0);
		chk_bit(ns_state_read_granted, 1'b1, "ns kept");
		done("grant");
		// auto clean disable with engine lat drawn from the seed, 2 to 9
		cfg_wr(1'b1, 1'b1, 1'b1);
		tick();
		clr(4'hf);
		dis_maint_bypass = 1'b0;
		cfg_wr(1'b0, 1'b0, 1'b1);
		tick();
		chk_bit(cache_enabled, 1'b1, "ns disable");
		seed = lfsr_next(seed);
		lat = {5'h00, seed[2:0]} + 8'h02;
		cfg_wr(1'b1, 1'b0, 1'b1);
		chk_bit(maint_start, 1'b1, "auto start");
		chk_vec({2'h0, maint_kind}, 4'h1, "auto kind");
		for (i = 0; i < 40 && ahb_stall === 1'b1; i++) begin
			chk_bit(cache_enabled, 1'b1, "held on");
			chk_bit(ongoing_en_dis, 1'b1, "busy");
			tick();
		end
		chk_bit(i > 2, 1'b1, "stalled");
		chk_bit(ahb_stall, 1'b0, "unstall");
		tick();
		chk_bit(cache_enabled, 1'b0, "auto off");
		chk_vec(secure_irq_status, 4'h1, "auto flag");
		done("auto_disable");
		// clean then disable back to back, bypass high
		dis_maint_bypass = 1'b1;
		cfg_wr(1'b1, 1'b1, 1'b1);
		tick();
		clr(4'hf);
		seed = lfsr_next(seed);
		lat = {5'h00, seed[2:0]} + 8'h04;
		st0 = n_starts;
		mreq(1'b1, MAINT_CLEAN);
		chk_bit(ongoing_maint, 1'b1, "clean run");
		cfg_wr(1'b1, 1'b0, 1'b1);
		chk_bit(ongoing_en_dis, 1'b1, "queued");
		for (i = 0; i < 40 && ongoing_maint === 1'b1; i++) begin
			chk_bit(cache_enabled, 1'b1, "order");
			tick();
		end
		chk_bit(secure_irq_status[IRQ_MAINT_DONE], 1'b1, "mdone");
		for (i = 0; i < 4 && cache_enabled === 1'b1; i++) tick();
		chk_bit(cache_enabled, 1'b0, "queued off");
		chk_vec(secure_irq_status, 4'h3, "both flags");
		// clear only the maintenance flag, disable flag must stay
		clr(4'h2);
		chk_vec(secure_irq_status, 4'h1, "keep dis");
		chk_bit(n_starts == st0 + 1, 1'b1, "one start");
		done("clean_then_disable");
		// random interrupt enables and state reads
		for (int k = 0; k < 16; k++) begin
			seed = lfsr_next(seed);
			ien(seed[3:0]);
			chk_vec(secure_irq_enable, seed[3:0], "rnd mask");
			chk_bit(secure_irq, |(4'h1 & seed[3:0]), "rnd irq");
			rd(seed[4]);
			chk_bit(state_read_valid, 1'b1, "rnd read");
			chk_bit(state_read_data, 1'b0, "rnd data");
		end
		done("random");
		finish_test();
	end
endmodule

// ===== verification/maint_engine_model.sv
// behavioural model of the outside whole-cache maintenance engine
// assumes maint_start is a one-cycle pulse and lat is held meanwhile
module maint_engine_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic maint_start,
	input wire logic [7:0] lat,
	output logic maint_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy_reg;
	logic [7:0] cnt_reg;

	// count lat cycles after a start, then answer with one done pulse
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			maint_done <= 1'b0;
		end else begin
			maint_done <= 1'b0;
			if (maint_start) begin
				busy_reg <= 1'b1;
				cnt_reg <= lat;
			end else if (busy_reg && cnt_reg == 8'h00) begin
				busy_reg <= 1'b0;
				maint_done <= 1'b1;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end
endmodule
